// [logic/ntc_config_header.sv]
`timescale 1ns/1ps
// What this block does
// [R1] command bit 0 set lets primary-side I/O requests be answered, clear ignores them
// [R2] command bit 1 set lets primary-side memory requests be answered, clear ignores them
// [R3] bit 2 clear: no upstream requests; downstream ones get unsupported-request completions
// [R4] bit 6 set: normal parity actions; clear: parity errors may be ignored
// [R5] bit 8 enables fatal and non-fatal error reports to the root complex
// [R6] bit 10 set blocks legacy interrupt messages; clear allows them
// [R7] status bit 19 interrupt pending always reads zero
// [R8] status bit 20 reads one; byte 34h points to first capability
// [R9] status bit 24 set on primary parity error only with response enabled; write-one clears
// [R10] status bit 27 set on completer abort; write-one clears
// [R11] status bit 30 set on error message sent with reporting enabled; write-one clears
// [R12] status bit 31 set on poisoned packet received; write-one clears
// [R13] class code reads interface 00h, sub-class 80h, base class 06h
// [R14] header type byte reads 00h
// [R15] cache line size byte is read-write storage with no effect
// [R16] window base: bits 0 and 3 zero, 16:4 reserved, 31:17 writable
// [R17] window type field bits 2:1 reads 00b or 10b
// [R18] type 10b makes upper base writable; otherwise it reads zero
// [R19] extended chain: 100h id 0003h next C34h; C34h id 000Bh ends
// [R20] maker and part identifiers at offset zero are fixed read-only codes
// [R21] unsupported and reserved command and status bits read zero, ignore writes
// [R22] write-one clears, write-zero keeps; same-cycle event keeps the bit set
module ntc_config_header #(
  // arbitrary neutral identity values
  parameter logic [15:0] MAKER_ID = 16'h1234,
  parameter logic [15:0] PART_ID = 16'h5678,
  parameter logic [1:0] WINDOW_TYPE = ntc_pkg::BAR_TYPE_32
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic parity_err_in,
  input wire logic abort_in,
  input wire logic err_msg_req_in,
  input wire logic poison_in,
  input wire logic intx_req_in,
  input wire logic io_req_in,
  input wire logic mem_req_in,
  input wire logic up_req_in,
  input wire logic down_np_req_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic io_accept_out,
  output logic mem_accept_out,
  output logic up_grant_out,
  output logic unsup_cpl_out,
  output logic err_msg_out,
  output logic intx_msg_out,
  output logic parity_act_out,
  output logic [31:0] window_base_low_out,
  output logic [31:0] window_base_high_out
);
  initial
  begin
    if (WINDOW_TYPE != ntc_pkg::BAR_TYPE_32 && WINDOW_TYPE != ntc_pkg::BAR_TYPE_64)
    begin
      $error("window type must be 32-bit or 64-bit");
    end
  end

  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  wire [3:0] sticky_reg;
  logic [7:0] cache_line_reg;
  logic [7:0] cache_line_next;
  logic [14:0] bar0_base_reg;
  logic [14:0] bar0_base_next;
  logic [31:0] bar1_reg;
  logic [31:0] bar1_next;
  logic [31:0] rdata_next;

  // address decode
  wire hit_ident = cfg_addr_in == ntc_pkg::OFS_IDENT;
  wire hit_cmd = cfg_addr_in == ntc_pkg::OFS_CMD_STAT;
  wire hit_class = cfg_addr_in == ntc_pkg::OFS_CLASS;
  wire hit_misc = cfg_addr_in == ntc_pkg::OFS_MISC;
  wire hit_bar0 = cfg_addr_in == ntc_pkg::OFS_BAR0;
  wire hit_bar1 = cfg_addr_in == ntc_pkg::OFS_BAR1;
  wire hit_cap = cfg_addr_in == ntc_pkg::OFS_CAP_PTR;
  wire hit_ext1 = cfg_addr_in == ntc_pkg::OFS_EXT_FIRST;
  wire hit_ext2 = cfg_addr_in == ntc_pkg::OFS_EXT_SECOND;
  wire wr_cmd = cfg_wr_in && hit_cmd;
  wire window64 = WINDOW_TYPE == ntc_pkg::BAR_TYPE_64;

  // byte-enable merge
  wire [31:0] be_mask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}}, {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
  wire [15:0] cmd_wmask = ntc_pkg::CMD_WRITE_MASK & be_mask[15:0];
  assign cmd_next = wr_cmd ? ((cmd_reg & ~cmd_wmask) | (cfg_wdata_in[15:0] & cmd_wmask)) : cmd_reg; // see [R21]

  // sticky events; parity only logged while response enabled
  wire perr_en = cmd_reg[ntc_pkg::CMD_PERR_RESP];
  wire rep_en = cmd_reg[ntc_pkg::CMD_ERR_REPORT];
  wire err_send = err_msg_req_in && rep_en; // see [R5]
  wire [3:0] sticky_set = {poison_in, err_send, abort_in, parity_err_in && perr_en}; // see [R9] [R10] [R11] [R12]
  wire [15:0] st_wr = (wr_cmd) ? (cfg_wdata_in[31:16] & be_mask[31:16]) : 16'h0000;
  wire [3:0] sticky_clr = {st_wr[ntc_pkg::ST_POISON], st_wr[ntc_pkg::ST_SYS_ERR],
                           st_wr[ntc_pkg::ST_ABORT], st_wr[ntc_pkg::ST_PARITY]};
  wire io_en = cmd_reg[ntc_pkg::CMD_IO_EN];
  wire mem_en = cmd_reg[ntc_pkg::CMD_MEM_EN];
  wire master_en = cmd_reg[ntc_pkg::CMD_MASTER_EN];
  wire intx_en = !cmd_reg[ntc_pkg::CMD_INTX_DIS];

  wire [15:0] status_view = (16'h0001 << ntc_pkg::ST_CAP_LIST) // see [R8]
                          | ({15'h0000, sticky_reg[0]} << ntc_pkg::ST_PARITY)
                          | ({15'h0000, sticky_reg[1]} << ntc_pkg::ST_ABORT)
                          | ({15'h0000, sticky_reg[2]} << ntc_pkg::ST_SYS_ERR)
                          | ({15'h0000, sticky_reg[3]} << ntc_pkg::ST_POISON); // interrupt pending stays 0, see [R7]

  assign cache_line_next = (cfg_wr_in && hit_misc && cfg_be_in[0]) ? cfg_wdata_in[7:0] : cache_line_reg; // see [R15]

  wire [31:0] bar0_wmask = be_mask & 32'hFFFE0000;
  wire [31:0] bar0_full = {bar0_base_reg, 17'h00000};
  wire [31:0] bar0_merged = (bar0_full & ~bar0_wmask) | (cfg_wdata_in & bar0_wmask);
  assign bar0_base_next = (cfg_wr_in && hit_bar0) ? bar0_merged[31:ntc_pkg::BAR0_BASE_LSB] : bar0_base_reg; // see [R16]
  wire [31:0] bar0_view = {bar0_base_reg, 13'h0000, 1'b0, WINDOW_TYPE, 1'b0}; // see [R16] [R17]

  wire [31:0] bar1_merged = (bar1_reg & ~be_mask) | (cfg_wdata_in & be_mask);
  assign bar1_next = (cfg_wr_in && hit_bar1 && window64) ? bar1_merged : bar1_reg; // see [R18]
  wire [31:0] bar1_view = window64 ? bar1_reg : 32'h00000000; // see [R18]

  wire [31:0] ext1_view = {ntc_pkg::OFS_EXT_SECOND, ntc_pkg::EXT_CAP_VERSION, ntc_pkg::EXT_CAP_ID_FIRST}; // see [R19]
  wire [31:0] ext2_view = {12'h000, ntc_pkg::EXT_CAP_VERSION, ntc_pkg::EXT_CAP_ID_SECOND}; // see [R19]

  // read mux; unmapped offsets read zero
  always_comb
  begin
    if (hit_ident)
    begin
      rdata_next = {PART_ID, MAKER_ID}; // see [R20]
    end
    else if (hit_cmd)
    begin
      rdata_next = {status_view, cmd_reg};
    end
    else if (hit_class)
    begin
      rdata_next = {ntc_pkg::CLASS_BASE, ntc_pkg::CLASS_SUB, ntc_pkg::CLASS_PROG_IF, ntc_pkg::REVISION_RESET}; // see [R13]
    end
    else if (hit_misc)
    begin
      rdata_next = {8'h00, ntc_pkg::HEADER_TYPE0, 8'h00, cache_line_reg}; // see [R14]
    end
    else if (hit_bar0)
    begin
      rdata_next = bar0_view;
    end
    else if (hit_bar1)
    begin
      rdata_next = bar1_view;
    end
    else if (hit_cap)
    begin
      rdata_next = {24'h000000, ntc_pkg::FIRST_CAP_PTR}; // see [R8]
    end
    else if (hit_ext1)
    begin
      rdata_next = ext1_view;
    end
    else if (hit_ext2)
    begin
      rdata_next = ext2_view;
    end
    else
    begin
      rdata_next = 32'h00000000;
    end
  end

  // type bits show from reset on, not only after the first enabled edge
  localparam logic [31:0] WINDOW_LOW_RESET = {ntc_pkg::BAR0_BASE_RESET, 13'h0000, 1'b0, WINDOW_TYPE, 1'b0};
  wire [31:0] rdata_hold = cfg_rd_in ? rdata_next : 32'h00000000;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cmd_reg <= ntc_pkg::CMD_RESET;
    else if (clk_en_in)
      cmd_reg <= cmd_next;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cache_line_reg <= ntc_pkg::CACHE_LINE_RESET;
    else if (clk_en_in)
      cache_line_reg <= cache_line_next;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      bar0_base_reg <= ntc_pkg::BAR0_BASE_RESET;
    else if (clk_en_in)
      bar0_base_reg <= bar0_base_next;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      bar1_reg <= ntc_pkg::BAR1_RESET;
    else if (clk_en_in)
      bar1_reg <= bar1_next;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cfg_rdata_out <= 32'h00000000;
    else if (clk_en_in)
      cfg_rdata_out <= rdata_hold;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cfg_rvalid_out <= 1'b0;
    else if (clk_en_in)
      cfg_rvalid_out <= cfg_rd_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      window_base_low_out <= WINDOW_LOW_RESET; // see [R17]
    else if (clk_en_in)
      window_base_low_out <= bar0_view;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      window_base_high_out <= 32'h00000000;
    else if (clk_en_in)
      window_base_high_out <= bar1_view;
  end

  ntc_gate_reg io_gate_inst ( // see [R1]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(io_req_in),
    .allow_in(io_en),
    .grant_out(io_accept_out)
  );

  ntc_gate_reg mem_gate_inst ( // see [R2]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(mem_req_in),
    .allow_in(mem_en),
    .grant_out(mem_accept_out)
  );

  ntc_gate_reg up_gate_inst ( // see [R3]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(up_req_in),
    .allow_in(master_en),
    .grant_out(up_grant_out)
  );

  ntc_gate_reg unsup_gate_inst ( // see [R3]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(down_np_req_in),
    .allow_in(!master_en),
    .grant_out(unsup_cpl_out)
  );

  ntc_gate_reg err_gate_inst ( // see [R5]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(err_msg_req_in),
    .allow_in(rep_en),
    .grant_out(err_msg_out)
  );

  ntc_gate_reg intx_gate_inst ( // see [R6]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(intx_req_in),
    .allow_in(intx_en),
    .grant_out(intx_msg_out)
  );

  ntc_gate_reg parity_gate_inst ( // see [R4]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .req_in(parity_err_in),
    .allow_in(perr_en),
    .grant_out(parity_act_out)
  );

  ntc_w1c_bit parity_flag_inst ( // see [R9]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .set_in(sticky_set[0]),
    .clr_in(sticky_clr[0]),
    .flag_out(sticky_reg[0])
  );

  ntc_w1c_bit abort_flag_inst ( // see [R10]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .set_in(sticky_set[1]),
    .clr_in(sticky_clr[1]),
    .flag_out(sticky_reg[1])
  );

  ntc_w1c_bit sys_err_flag_inst ( // see [R11]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .set_in(sticky_set[2]),
    .clr_in(sticky_clr[2]),
    .flag_out(sticky_reg[2])
  );

  ntc_w1c_bit poison_flag_inst ( // see [R12]
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .set_in(sticky_set[3]),
    .clr_in(sticky_clr[3]),
    .flag_out(sticky_reg[3])
  );
endmodule

module ntc_gate_reg (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic req_in,
  input wire logic allow_in,
  output logic grant_out
);
  // registered so the top outputs come straight from flops
  wire grant_next = req_in && allow_in;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      grant_out <= 1'b0;
    else if (clk_en_in)
      grant_out <= grant_next;
  end
endmodule

module ntc_w1c_bit (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  // set beats a same-cycle clear so no event is lost
  wire flag_next = set_in || (flag_out && !clr_in); // see [R22]

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      flag_out <= 1'b0;
    else if (clk_en_in)
      flag_out <= flag_next;
  end
endmodule

// [logic/ntc_pkg.sv]
package ntc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_IDENT = 12'h000;
  localparam logic [11:0] OFS_CMD_STAT = 12'h004;
  localparam logic [11:0] OFS_CLASS = 12'h008;
  localparam logic [11:0] OFS_MISC = 12'h00C;
  localparam logic [11:0] OFS_BAR0 = 12'h010;
  localparam logic [11:0] OFS_BAR1 = 12'h014;
  localparam logic [11:0] OFS_CAP_PTR = 12'h034;
  localparam logic [11:0] OFS_EXT_FIRST = 12'h100;
  localparam logic [11:0] OFS_EXT_SECOND = 12'hC34;
  // command bit positions
  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_MASTER_EN = 2;
  localparam int CMD_PERR_RESP = 6;
  localparam int CMD_ERR_REPORT = 8;
  localparam int CMD_INTX_DIS = 10;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0547;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // status bit positions, counted inside the upper half-word
  localparam int ST_INT_PEND = 3;
  localparam int ST_CAP_LIST = 4;
  localparam int ST_PARITY = 8;
  localparam int ST_ABORT = 11;
  localparam int ST_SYS_ERR = 14;
  localparam int ST_POISON = 15;
  // fixed read values, plus the reset value of the writable cache line size byte
  localparam logic [7:0] REVISION_RESET = 8'h00;
  localparam logic [7:0] CLASS_PROG_IF = 8'h00;
  localparam logic [7:0] CLASS_SUB = 8'h80;
  localparam logic [7:0] CLASS_BASE = 8'h06;
  localparam logic [7:0] HEADER_TYPE0 = 8'h00;
  localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
  localparam logic [7:0] FIRST_CAP_PTR = 8'h40;
  localparam logic [15:0] EXT_CAP_ID_FIRST = 16'h0003;
  localparam logic [15:0] EXT_CAP_ID_SECOND = 16'h000B;
  localparam logic [3:0] EXT_CAP_VERSION = 4'h1;
  // window base register layout
  localparam int BAR0_BASE_LSB = 17;
  localparam logic [1:0] BAR_TYPE_32 = 2'h0;
  localparam logic [1:0] BAR_TYPE_64 = 2'h2;
  localparam logic [14:0] BAR0_BASE_RESET = 15'h0000;
  localparam logic [31:0] BAR1_RESET = 32'h00000000;
endpackage

// [testbench/ntc_checker.sv]
`timescale 1ns/1ps
module ntc_checker #(
  parameter logic [1:0] WINDOW_TYPE = 2'h0
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic cfg_rd_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic io_req_in,
  input wire logic up_req_in,
  input wire logic down_np_req_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic io_accept_out,
  input wire logic up_grant_out,
  input wire logic unsup_cpl_out,
  input wire logic [31:0] window_base_low_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_RVALID_LATENCY:
    assert property (clk_en_in && cfg_rd_in |=> cfg_rvalid_out) else $error("read answer late");
  AST_IO_GATE:
    assert property (io_accept_out && $past(clk_en_in) |-> $past(io_req_in)) else $error("io accept without request");
  AST_UP_GATE:
    assert property (up_grant_out && $past(clk_en_in) |-> $past(up_req_in)) else $error("grant without request");
  AST_UNSUP_SRC:
    assert property (unsup_cpl_out && $past(clk_en_in) |-> $past(down_np_req_in)) else $error("stray unsupported");
  AST_UP_XOR_UNSUP:
    assert property (!(up_grant_out && unsup_cpl_out)) else $error("grant and unsupported together");
  AST_STATUS_FIXED:
    assert property (clk_en_in && cfg_rd_in && cfg_addr_in == 12'h004 |=> cfg_rdata_out[20:19] == 2'h2)
      else $error("status fixed bits wrong");
  AST_CLASS_CODE:
    assert property (clk_en_in && cfg_rd_in && cfg_addr_in == 12'h008 |=> cfg_rdata_out[31:8] == 24'h068000)
      else $error("class code wrong");
  AST_HEADER_TYPE:
    assert property (clk_en_in && cfg_rd_in && cfg_addr_in == 12'h00C |=> cfg_rdata_out[31:8] == 24'h000000)
      else $error("header word wrong");
  AST_BASE_LOW_FIXED:
    assert property (window_base_low_out[16:0] == {13'h0000, WINDOW_TYPE, 1'b0}) else $error("base low fixed bits");
  cover property (io_accept_out);
  cover property (unsup_cpl_out);
  cover property (cfg_rvalid_out && cfg_rdata_out[30]);
endmodule
bind ntc_config_header ntc_checker #(.WINDOW_TYPE(WINDOW_TYPE)) ntc_checker_inst (.sys_clk_in, .rst_b_in,
  .clk_en_in, .cfg_rd_in, .cfg_addr_in, .io_req_in, .up_req_in, .down_np_req_in, .cfg_rdata_out,
  .cfg_rvalid_out, .io_accept_out, .up_grant_out, .unsup_cpl_out, .window_base_low_out);

// [testbench/ntc_host_model.sv]
`timescale 1ns/1ps
module ntc_host_model (
  input wire logic sys_clk_in,
  input wire logic [31:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in,
  output logic cfg_wr_out = 1'b0,
  output logic cfg_rd_out = 1'b0,
  output logic [11:0] cfg_addr_out = 12'h000,
  output logic [3:0] cfg_be_out = 4'h0,
  output logic [31:0] cfg_wdata_out = 32'h00000000
);
  // entered just after an edge; request held through the taking edge
  task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
    output logic [32:0] r);
    cfg_wr_out = wr;
    cfg_rd_out = !wr;
    cfg_addr_out = a;
    cfg_be_out = be;
    cfg_wdata_out = d;
    @(posedge sys_clk_in);
    #1;
    r = {cfg_rvalid_in, cfg_rdata_in};
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    // released bus shows no stale value
    cfg_wdata_out = ~d;
    cfg_addr_out = ~a;
    // one idle edge so the next call never re-drives a strobe in this time step
    @(posedge sys_clk_in);
    #1;
  endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] RA [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h034, 12'h100,
    12'hC34, 12'h200};
  localparam logic [31:0] RX [10] = '{32'h56781234, 32'h00100000, 32'h06800000, 32'h0, 32'h4, 32'h0, 32'h40,
    32'hC3410003, 32'h0001000B, 32'h0};
  localparam logic [15:0] CX [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0040, 16'h0100, 16'h0400,
    16'hFFFF};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [8:0] ev = 9'h000;
  logic wr, rd, rv;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, lo, hi;
  logic [6:0] gates;
  logic [32:0] r;
  logic [15:0] c;
  int n_fail = 0;
  int n_checks = 0;
  initial
  begin
    forever #2 clk = ~clk;
  end
  ntc_config_header #(.WINDOW_TYPE(ntc_pkg::BAR_TYPE_64)) ntc_config_header_inst (.sys_clk_in(clk),
    .rst_b_in(rst_b), .clk_en_in(clk_en), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_be_in(be),
    .cfg_wdata_in(wd), .parity_err_in(ev[0]), .abort_in(ev[1]), .err_msg_req_in(ev[2]), .poison_in(ev[3]),
    .intx_req_in(ev[4]), .io_req_in(ev[5]), .mem_req_in(ev[6]), .up_req_in(ev[7]), .down_np_req_in(ev[8]),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rv), .io_accept_out(gates[3]), .mem_accept_out(gates[4]),
    .up_grant_out(gates[5]), .unsup_cpl_out(gates[6]), .err_msg_out(gates[1]), .intx_msg_out(gates[2]),
    .parity_act_out(gates[0]), .window_base_low_out(lo), .window_base_high_out(hi));
  ntc_host_model host_inst (.sys_clk_in(clk), .cfg_rdata_in(rdata), .cfg_rvalid_in(rv), .cfg_wr_out(wr),
    .cfg_rd_out(rd), .cfg_addr_out(addr), .cfg_be_out(be), .cfg_wdata_out(wd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wrd(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    host_inst.access(1'b1, a, b, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host_inst.access(1'b0, a, 4'h0, 32'h0, r);
    check("read valid", {31'h0, r[32]}, 32'h1);
    check($sformatf("read %h", a), r[31:0], exp);
  endtask
  // events held one cycle, gates looked at just after the edge that registers them, once events are cleared
  task automatic fire(input logic [8:0] m, input logic [6:0] exp);
    ev = m;
    @(posedge clk);
    #1;
    ev = 9'h000;
    check("gates", {25'h0, gates}, {25'h0, exp});
  endtask
  initial
  begin
    for (int p = 0; p < 2; p++)
    begin
      rst_b = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      rst_b = 1'b1;
      for (int i = 0; i < 10; i++)
        rdc(RA[i], RX[i]);
      if (p == 0)
      begin
        wrd(12'h004, 4'hF, 32'hFFFFFFFF);
        rdc(12'h004, 32'h00100547);
        wrd(12'h008, 4'hF, 32'hFFFFFFFF);
        wrd(12'h00C, 4'hF, 32'hFFFFFFFF);
        wrd(12'h00C, 4'h0, 32'h0);
        wrd(12'h010, 4'hF, 32'hFFFFFFFF);
        wrd(12'h014, 4'hF, 32'hFFFFFFFF);
        rdc(12'h008, 32'h06800000);
        rdc(12'h00C, 32'h000000FF);
        rdc(12'h010, 32'hFFFE0004);
        rdc(12'h014, 32'hFFFFFFFF);
        check("base high", hi, 32'hFFFFFFFF);
        check("base low", lo, 32'hFFFE0004);
        for (int i = 0; i < 8; i++)
        begin
          c = CX[i] & ntc_pkg::CMD_WRITE_MASK;
          wrd(12'h004, 4'hF, {16'hFFFF, CX[i]});
          fire(9'h1FF, {!c[2], c[2], c[1], c[0], !c[10], c[8], c[6]});
          rdc(12'h004, {1'b1, c[8], 4'h2, 1'b0, c[6], 8'h10, c});
        end
        // clear racing a new abort: the event must win
        ev = 9'h002;
        fork
          wrd(12'h004, 4'hC, 32'h08000000);
          begin
            @(posedge clk);
            #1;
            ev = 9'h000;
          end
        join
        wrd(12'h004, 4'hC, 32'h0);
        rdc(12'h004, 32'hC9100547);
        wrd(12'h004, 4'h3, 32'hFFFF0000);
        wrd(12'h004, 4'hC, 32'h09000000);
        rdc(12'h004, 32'hC0100000);
        clk_en = 1'b0;
        fire(9'h1FF, 7'h00);
        check("frozen base low", lo, 32'hFFFE0004);
        clk_en = 1'b1;
      end
    end
    tally_and_finish();
  end
endmodule
